// *** rtl/hsa_pkg.sv ***
// Package with register map, encodings and reset values of the alarm block.
package hsa_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_SEL      = 8'h00;
  localparam logic [7:0] OFF_ENABLE   = 8'h04;
  localparam logic [7:0] OFF_MAINTAIN = 8'h08;
  localparam logic [7:0] OFF_DEADBAND = 8'h0c;
  localparam logic [7:0] OFF_LOW_TEMP = 8'h10;
  localparam logic [7:0] OFF_HIGH_TEMP = 8'h14;
  localparam logic [7:0] OFF_LOW_CUR  = 8'h18;
  localparam logic [7:0] OFF_HIGH_CUR = 8'h1c;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  localparam logic [7:0] OFF_MEAS     = 8'h24;

  // ==========================================================
  // Status register bit positions
  localparam int ST_HEAT = 0;
  localparam int ST_LT   = 1;
  localparam int ST_HT   = 2;
  localparam int ST_LC   = 3;
  localparam int ST_HC   = 4;
  localparam int ST_PE   = 5;

  // ==========================================================
  // Special setpoint codes and ranges (temperatures in whole degC)
  localparam logic [15:0] TEMP_OFF  = 16'h7fff;
  localparam logic [15:0] TEMP_NONE = 16'h7ffe;
  localparam logic [15:0] TEMP_MIN  = 16'hffce;
  localparam logic [15:0] TEMP_MAX  = 16'h01f4;
  localparam logic [5:0]  CUR_OFF   = 6'h00;
  localparam logic [5:0]  CUR_MAX   = 6'h3c;
  localparam logic [3:0]  CUR_STEP_TENTHS = 4'h5;
  localparam logic [6:0]  DUTY_FULL = 7'h64;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_MAINTAIN = 16'h0014;
  localparam logic [15:0] RST_LOW_TEMP = 16'h0005;
  localparam logic [15:0] RST_HIGH_TEMP = TEMP_OFF;
  localparam logic [7:0]  RST_DEADBAND = 8'h02;
  localparam logic [5:0]  RST_CUR      = CUR_OFF;

  // ==========================================================
  // One heater circuit: setpoints, outputs and last measurement.
  typedef struct packed {
    logic        en;
    logic        heat;
    logic        a_lt;
    logic        a_ht;
    logic        a_lc;
    logic        a_hc;
    logic [15:0] sp_main;
    logic [7:0]  deadband;
    logic [15:0] sp_lt;
    logic [15:0] sp_ht;
    logic [5:0]  sp_lc;
    logic [5:0]  sp_hc;
    logic [15:0] last_temp;
    logic [15:0] last_cur;
  } hsa_ckt_s;

  // A write request from either source.
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
  } hsa_wr_s;

  // A measurement for one circuit.
  typedef struct packed {
    logic        valid;
    logic [7:0]  circ;
    logic [15:0] temp;
    logic [15:0] cur;
    logic [6:0]  duty;
    logic        derated;
  } hsa_meas_s;

endpackage

// *** rtl/hsa_alarm.sv ***
// Heater setpoint, on-off control and alarm evaluation for all circuits.
// What this block does
// - Keypad setpoint writes only take effect while program-enable is set.
// - Serial writes are accepted whatever the program-enable switch says.
// - Circuit is named module number plus index; selection picks setpoints.
// - Per-circuit enable, default on; off stops control and blocks access.
// - On-off control energises below maintain minus deadband; default 20 C.
// - De-energise above maintain plus deadband; hold output in between.
// - Maintain none keeps heater on and monitors; off keeps on, no control.
// - Low temperature alarm when temp at or below setpoint; default 5 C.
// - Temperature alarm setpoints unavailable while maintain is off.
// - High temperature alarm when temp at or above setpoint; default off.
// - High temperature alarm clears itself when temp drops below setpoint.
// - Low current alarm when current at or below setpoint; default off.
// - Low current alarm clears when current rises above setpoint.
// - High current alarm when current at or above setpoint.
// - High current alarm clears when current falls below setpoint.
// - Current setpoints are held as counts of 0.5 A steps.
// - An alarm setpoint at its off value never raises that alarm.
// - Current thresholds refer to the heater at full power.
// - High current alarm is held off while derated with duty above zero and below full.
// - Measured current is scaled to full power before comparing.
module hsa_alarm #(
  parameter int N_CIRC = 4,
  parameter logic [7:0] MODULE_NUM = 8'h01
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              kp_wr,
  input  wire logic [7:0]        kp_addr,
  input  wire logic [31:0]       kp_wdata,
  input  wire logic              prog_en_pin,
  input  wire hsa_pkg::hsa_meas_s meas,
  output logic [N_CIRC-1:0]      heat_on,
  output logic [N_CIRC-1:0]      alm_low_temp,
  output logic [N_CIRC-1:0]      alm_high_temp,
  output logic [N_CIRC-1:0]      alm_low_cur,
  output logic [N_CIRC-1:0]      alm_high_cur
);

  // ==========================================================
  // Parameter check
  if (N_CIRC < 1 || N_CIRC > 256)
  begin : g_bad
    $error("N_CIRC must lie between 1 and 256.");
  end

  // ==========================================================
  // State
  typedef struct packed {
    hsa_pkg::hsa_ckt_s [N_CIRC-1:0] ckt;
    logic [7:0]                     sel;
    logic [2:0]                     pe_sync;
    logic                           pe;
    logic [31:0]                    rdata;
  } hsa_state_s;

  hsa_state_s state_ff;
  hsa_state_s nxt_state;

  hsa_pkg::hsa_ckt_s cur_c;
  hsa_pkg::hsa_wr_s  req;
  logic [31:0]       rd_val;
  logic              sel_blocked;
  logic              temp_locked;

  // ==========================================================
  // Selected circuit and write source
  always_comb
  begin
    cur_c = state_ff.ckt[state_ff.sel];
    sel_blocked = !cur_c.en;
    temp_locked = (cur_c.sp_main == hsa_pkg::TEMP_OFF);
    // serial always
    // Serial write wins over keypad in the same cycle.
    // The keypad loses quietly; the host is expected to own the block
    // while it is writing.
    if (reg_wr)
    begin
      req = '{wr: 1'b1, addr: reg_addr, data: reg_wdata};
    end
    else
    begin
      req = '{wr: kp_wr & state_ff.pe, addr: kp_addr, data: kp_wdata};
    end
  end

  // ==========================================================
  // Read mux for the selected circuit
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (reg_addr)
      hsa_pkg::OFF_SEL:
        rd_val = {16'h0000, MODULE_NUM, state_ff.sel};
      hsa_pkg::OFF_ENABLE:
        rd_val = {31'h0000_0000, cur_c.en};
      hsa_pkg::OFF_STATUS:
        rd_val = {26'h000_0000, state_ff.pe, cur_c.a_hc, cur_c.a_lc,
                  cur_c.a_ht, cur_c.a_lt, cur_c.heat};
      default:
        if (!sel_blocked)
        begin
          unique case (reg_addr)
            hsa_pkg::OFF_MAINTAIN:
              rd_val = {16'h0000, cur_c.sp_main};
            hsa_pkg::OFF_DEADBAND:
              rd_val = {24'h00_0000, cur_c.deadband};
            // shown as off
            // While maintain is off the temperature alarm setpoints read as off.
            hsa_pkg::OFF_LOW_TEMP:
              rd_val = {16'h0000,
                        temp_locked ? hsa_pkg::TEMP_OFF : cur_c.sp_lt};
            hsa_pkg::OFF_HIGH_TEMP:
              rd_val = {16'h0000,
                        temp_locked ? hsa_pkg::TEMP_OFF : cur_c.sp_ht};
            hsa_pkg::OFF_LOW_CUR:
              rd_val = {26'h000_0000, cur_c.sp_lc};
            hsa_pkg::OFF_HIGH_CUR:
              rd_val = {26'h000_0000, cur_c.sp_hc};
            hsa_pkg::OFF_MEAS:
              rd_val = {cur_c.last_cur, cur_c.last_temp};
            default:
              rd_val = 32'h0000_0000;
          endcase
        end
    endcase
  end

  // ==========================================================
  // Next state: synchroniser, measurement evaluation, writes
  always_comb
  begin
    logic signed [16:0] t;
    logic signed [16:0] sp;
    logic signed [16:0] db;
    logic [23:0]        cur_x100;
    logic [23:0]        lc_thr;
    logic [23:0]        hc_thr;
    logic               t_ok;
    logic [15:0]        wv;
    hsa_pkg::hsa_ckt_s  c;
    t = '0;
    sp = '0;
    db = '0;
    cur_x100 = '0;
    lc_thr = '0;
    hc_thr = '0;
    t_ok = 1'b0;
    wv = '0;
    c = '0;
    nxt_state = state_ff;

    // Program-enable switch: three flops, change taken once two agree.
    // The switch is a hand-set level from outside the clock domain, so
    // a bounce lasting a single clock cycle on the pin never reaches the keypad gate.
    nxt_state.pe_sync = {state_ff.pe_sync[1:0], prog_en_pin};
    if (state_ff.pe_sync[1] == state_ff.pe_sync[2])
    begin
      nxt_state.pe = state_ff.pe_sync[2];
    end

    // Read data stand only in the cycle after the strobe.
    // Holding zero otherwise lets several slaves share an or-ed bus.
    nxt_state.rdata = reg_rd ? rd_val : 32'h0000_0000;

    // evaluate on measurement
    // Indices at or above N_CIRC belong to no circuit here and are
    // dropped; the compare is one bit wider so that 256 circuits fit.
    if (meas.valid && {1'b0, meas.circ} < 9'(N_CIRC))
    begin
      c = state_ff.ckt[meas.circ];
      t = 17'(signed'(meas.temp));
      sp = 17'(signed'(c.sp_main));
      db = signed'({9'h000, c.deadband});
      c.last_temp = meas.temp;
      c.last_cur = meas.cur;
      if (!c.en)
      begin
        // control stopped
        // A disabled circuit drops its heater and alarms at its next
        // measurement, so an idle circuit raises nothing.
        c.heat = 1'b0;
        c.a_lt = 1'b0;
        c.a_ht = 1'b0;
        c.a_lc = 1'b0;
        c.a_hc = 1'b0;
      end
      else
      begin
        t_ok = 1'b1;
        if (c.sp_main == hsa_pkg::TEMP_OFF)
        begin
          c.heat = 1'b1;
          t_ok = 1'b0;
        end
        else if (c.sp_main == hsa_pkg::TEMP_NONE)
        begin
          c.heat = 1'b1;
        end
        else if (t < sp - db)
        begin
          c.heat = 1'b1;
        end
        else if (t > sp + db)
        begin
          c.heat = 1'b0;
        end
        c.a_lt = t_ok && c.sp_lt != hsa_pkg::TEMP_OFF &&
                 t <= 17'(signed'(c.sp_lt));
        c.a_ht = t_ok && c.sp_ht != hsa_pkg::TEMP_OFF &&
                 t >= 17'(signed'(c.sp_ht));
        // scale by duty
        // Both sides are multiplied up instead of dividing the
        // measurement by duty, which keeps the compare exact and cheap.
        cur_x100 = 24'(meas.cur) * 24'(hsa_pkg::DUTY_FULL);
        lc_thr = 24'(c.sp_lc) * 24'(hsa_pkg::CUR_STEP_TENTHS) *
                 24'(meas.duty);
        hc_thr = 24'(c.sp_hc) * 24'(hsa_pkg::CUR_STEP_TENTHS) *
                 24'(meas.duty);
        // A zero duty gives no usable current, so the current alarms keep
        // their last state until a measurement with the heater driven.
        if (meas.duty != 7'h00)
        begin
          c.a_lc = c.sp_lc != hsa_pkg::CUR_OFF && cur_x100 <= lc_thr;
          c.a_hc = c.sp_hc != hsa_pkg::CUR_OFF && cur_x100 >= hc_thr &&
                   !(meas.derated && meas.duty < hsa_pkg::DUTY_FULL);
        end
      end
      nxt_state.ckt[meas.circ] = c;
    end

    // setpoints only
    // Writes touch setpoint fields; alarm flags change only by evaluation.
    // A write and a measurement in the same cycle both land: the
    // measurement is judged on the old setpoint, the new one counts next.
    wv = req.data[15:0];
    if (req.wr)
    begin
      if (req.addr == hsa_pkg::OFF_SEL)
      begin
        // select circuit
        // The index is widened by one bit so a full 256-circuit build
        // still accepts every index.
        if (req.data[15:8] == MODULE_NUM &&
            {1'b0, req.data[7:0]} < 9'(N_CIRC))
        begin
          nxt_state.sel = req.data[7:0];
        end
      end
      else if (req.addr == hsa_pkg::OFF_ENABLE)
      begin
        nxt_state.ckt[state_ff.sel].en = req.data[0];
      end
      else if (!sel_blocked)
      begin
        unique case (req.addr)
          hsa_pkg::OFF_MAINTAIN:
            if (wv == hsa_pkg::TEMP_OFF || wv == hsa_pkg::TEMP_NONE ||
                (signed'(wv) >= signed'(hsa_pkg::TEMP_MIN) &&
                 signed'(wv) <= signed'(hsa_pkg::TEMP_MAX)))
            begin
              nxt_state.ckt[state_ff.sel].sp_main = wv;
            end
          hsa_pkg::OFF_DEADBAND:
            nxt_state.ckt[state_ff.sel].deadband = req.data[7:0];
          hsa_pkg::OFF_LOW_TEMP, hsa_pkg::OFF_HIGH_TEMP:
            if (!temp_locked && (wv == hsa_pkg::TEMP_OFF ||
                (signed'(wv) >= signed'(hsa_pkg::TEMP_MIN) &&
                 signed'(wv) <= signed'(hsa_pkg::TEMP_MAX))))
            begin
              if (req.addr == hsa_pkg::OFF_LOW_TEMP)
              begin
                nxt_state.ckt[state_ff.sel].sp_lt = wv;
              end
              else
              begin
                nxt_state.ckt[state_ff.sel].sp_ht = wv;
              end
            end
          hsa_pkg::OFF_LOW_CUR:
            if (req.data[31:6] == 26'h000_0000 &&
                req.data[5:0] <= hsa_pkg::CUR_MAX)
            begin
              nxt_state.ckt[state_ff.sel].sp_lc = req.data[5:0];
            end
          hsa_pkg::OFF_HIGH_CUR:
            if (req.data[31:6] == 26'h000_0000 &&
                req.data[5:0] <= hsa_pkg::CUR_MAX)
            begin
              nxt_state.ckt[state_ff.sel].sp_hc = req.data[5:0];
            end
          default:
            nxt_state.sel = state_ff.sel;
        endcase
      end
    end
  end

  // ==========================================================
  // State register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < N_CIRC; i++)
      begin
        state_ff.ckt[i] <= '{en: 1'b1, heat: 1'b0, a_lt: 1'b0,
                             a_ht: 1'b0, a_lc: 1'b0, a_hc: 1'b0,
                             sp_main: hsa_pkg::RST_MAINTAIN,
                             deadband: hsa_pkg::RST_DEADBAND,
                             sp_lt: hsa_pkg::RST_LOW_TEMP,
                             sp_ht: hsa_pkg::RST_HIGH_TEMP,
                             sp_lc: hsa_pkg::RST_CUR,
                             sp_hc: hsa_pkg::RST_CUR,
                             last_temp: 16'h0000, last_cur: 16'h0000};
      end
      state_ff.sel <= 8'h00;
      state_ff.pe_sync <= 3'h0;
      state_ff.pe <= 1'b0;
      state_ff.rdata <= 32'h0000_0000;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs straight from the state flops
  // Every output is a bit of state_ff, so no logic follows a flop.
  assign reg_rdata = state_ff.rdata;

  for (genvar g = 0; g < N_CIRC; g++)
  begin : g_out
    assign heat_on[g]       = state_ff.ckt[g].heat;
    assign alm_low_temp[g]  = state_ff.ckt[g].a_lt;
    assign alm_high_temp[g] = state_ff.ckt[g].a_ht;
    assign alm_low_cur[g]   = state_ff.ckt[g].a_lc;
    assign alm_high_cur[g]  = state_ff.ckt[g].a_hc;
  end

endmodule

// *** test/hsa_alarm_props.sv ***
// Port-level assertions for the heater setpoint and alarm block.
module hsa_alarm_props #(
  parameter int         N_CIRC     = 4,
  parameter logic [7:0] MODULE_NUM = 8'h01
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               kp_wr,
  input wire logic [7:0]         kp_addr,
  input wire logic [31:0]        kp_wdata,
  input wire logic               prog_en_pin,
  input wire hsa_pkg::hsa_meas_s meas,
  input wire logic [N_CIRC-1:0]  heat_on,
  input wire logic [N_CIRC-1:0]  alm_low_temp,
  input wire logic [N_CIRC-1:0]  alm_high_temp,
  input wire logic [N_CIRC-1:0]  alm_low_cur,
  input wire logic [N_CIRC-1:0]  alm_high_cur
);
  logic               wr_seen_ff;
  logic               nxt_wr_seen;
  logic               c0;
  logic signed [15:0] t0;

  // ==========================================================
  // Helpers
  // Any write since reset ends the stretch where defaults are known.
  assign nxt_wr_seen = wr_seen_ff | reg_wr | kp_wr;
  assign t0 = meas.temp;
  assign c0 = meas.valid && meas.circ == 8'h00 && !wr_seen_ff;

  // Register the write-seen flag.
  always_ff @(posedge clk)
  begin
    if (rst)
      wr_seen_ff <= 1'b0;
    else
      wr_seen_ff <= nxt_wr_seen;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_DEF_HEAT_ON: assert property (c0 && t0 < 18 |=> heat_on[0])
    else $error("heater off below the band");
  AST_DEF_HEAT_OFF: assert property (c0 && t0 > 22 |=> !heat_on[0])
    else $error("heater on above the band");
  AST_DEF_HOLD: assert property (c0 && t0 >= 18 && t0 <= 22 |=>
    heat_on[0] == $past(heat_on[0]))
    else $error("heater changed inside the band");
  AST_DEF_LOW_TEMP: assert property (c0 |=>
    alm_low_temp[0] == ($past(t0) <= 5))
    else $error("low temperature alarm wrong");
  AST_DEF_OFF: assert property (c0 |=>
    !alm_high_temp[0] && !alm_low_cur[0] && !alm_high_cur[0])
    else $error("disabled alarm raised");
  AST_HC_DERATED: assert property (meas.valid && meas.circ == 8'h00
    && meas.derated && meas.duty != 7'h00 && meas.duty < 7'h64
    |=> !alm_high_cur[0])
    else $error("high current alarm while derated");
  AST_OTHER_CIRC: assert property (meas.valid && meas.circ != 8'h00 |=>
    $stable({heat_on[0], alm_low_temp[0], alm_high_temp[0],
             alm_low_cur[0], alm_high_cur[0]}))
    else $error("circuit 0 changed by another circuit");
  AST_NO_MEAS_HOLD: assert property (!meas.valid |=>
    $stable({heat_on, alm_low_temp, alm_high_temp, alm_low_cur,
             alm_high_cur}))
    else $error("outputs changed without a measurement");
endmodule

bind hsa_alarm hsa_alarm_props #(
  .N_CIRC(N_CIRC), .MODULE_NUM(MODULE_NUM)
) i_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .kp_wr(kp_wr), .kp_addr(kp_addr), .kp_wdata(kp_wdata),
  .prog_en_pin(prog_en_pin), .meas(meas), .heat_on(heat_on),
  .alm_low_temp(alm_low_temp), .alm_high_temp(alm_high_temp),
  .alm_low_cur(alm_low_cur), .alm_high_cur(alm_high_cur)
);

// *** test/hsa_keypad.sv ***
// Operator keypad and program-enable switch model.
module hsa_keypad (
  input  wire logic clk,
  output logic      kp_wr,
  output logic [7:0]  kp_addr,
  output logic [31:0] kp_wdata,
  output logic      prog_en_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle keypad, switch in the disable position.
  initial
  begin
    kp_wr = 1'b0;
    kp_addr = 8'h00;
    kp_wdata = 32'h0;
    prog_en_pin = 1'b0;
  end

  // The switch is a slow level set by hand.
  task automatic set_switch(logic v);
    @(posedge clk);
    prog_en_pin <= v;
  endtask

  // One store key press; released lines carry no valid value.
  task automatic store(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    kp_wr <= 1'b1;
    kp_addr <= a;
    kp_wdata <= d;
    @(posedge clk);
    kp_wr <= 1'b0;
    kp_addr <= ~a;
    kp_wdata <= ~d;
  endtask
endmodule

// *** test/test_hsa_alarm.sv ***
// Self-checking bench for the heater setpoint and alarm block.
module test_hsa_alarm;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MOD = 8'h01;
  logic               clk, rst, reg_wr, reg_rd, kp_wr, prog_en_pin;
  logic [7:0]         reg_addr, kp_addr;
  logic [31:0]        reg_wdata, reg_rdata, kp_wdata;
  hsa_pkg::hsa_meas_s meas;
  logic [3:0]         heat_on, alm_low_temp, alm_high_temp;
  logic [3:0]         alm_low_cur, alm_high_cur;
  logic [4:0]         ex[4];
  int                 mismatches, tests_run, cyc, t, cu, du;
  int                 m[4], db[4], lt[4], ht[4], lc[4], hc[4];
  bit                 en[4];
  logic [7:0]         ra[8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                                8'h18, 8'h1c, 8'h40};
  logic [31:0]        rv[8] = '{32'h1, 32'h14, 32'h2, 32'h5, 32'h7fff,
                                32'h0, 32'h0, 32'h0};
  int                 tl[9] = '{17, 21, 23, 19, 17, 5, 6, -50, 100};

  hsa_alarm #(.N_CIRC(4), .MODULE_NUM(MOD)) i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .kp_wr(kp_wr), .kp_addr(kp_addr), .kp_wdata(kp_wdata),
    .prog_en_pin(prog_en_pin), .meas(meas), .heat_on(heat_on),
    .alm_low_temp(alm_low_temp), .alm_high_temp(alm_high_temp),
    .alm_low_cur(alm_low_cur), .alm_high_cur(alm_high_cur)
  );
  hsa_keypad i_kp (.clk(clk), .kp_wr(kp_wr), .kp_addr(kp_addr),
                   .kp_wdata(kp_wdata), .prog_en_pin(prog_en_pin));

  // ==========================================================
  // Clock, timeout and closing report
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // A hang is cut short well past the expected run length.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks run: %0d, mismatches: %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Bus tasks and expectation model
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask

  // Expected heater and alarm bits {hc, lc, ht, lt, heat} of a circuit.
  function automatic logic [4:0] exp_out(int c, int tt, int cc, int dd,
                                         bit dr);
    logic [4:0] e;
    bit         off;
    e = ex[c];
    off = m[c] == 32767;
    if (!en[c])
      return 5'h0;
    if (m[c] >= 32766)
      e[0] = 1'b1;
    else if (tt < m[c] - db[c])
      e[0] = 1'b1;
    else if (tt > m[c] + db[c])
      e[0] = 1'b0;
    e[1] = !off && lt[c] != 32767 && tt <= lt[c];
    e[2] = !off && ht[c] != 32767 && tt >= ht[c];
    if (dd != 0)
    begin
      e[3] = lc[c] != 0 && cc * 100 <= lc[c] * 5 * dd;
      e[4] = hc[c] != 0 && cc * 100 >= hc[c] * 5 * dd && !(dr && dd < 100);
    end
    return e;
  endfunction

  // One measurement, then the circuit's outputs one cycle later.
  task automatic mc(int c, int tt, int cc, int dd, bit dr);
    logic [4:0] o;
    @(posedge clk);
    meas <= {1'b1, 8'(c), 16'(tt), 16'(cc), 7'(dd), dr};
    @(posedge clk);
    meas.valid <= 1'b0;
    ex[c] = exp_out(c, tt, cc, dd, dr);
    @(negedge clk);
    o = {alm_high_cur[c], alm_low_cur[c], alm_high_temp[c],
         alm_low_temp[c], heat_on[c]};
    chk(32'(o[2:0]), 32'(ex[c][2:0]));
    chk(32'(o[4:3]), 32'(ex[c][4:3]));
  endtask

  task automatic defaults();
    for (int c = 0; c < 4; c++)
    begin
      m[c] = 20;
      db[c] = 2;
      lt[c] = 5;
      ht[c] = 32767;
      lc[c] = 0;
      hc[c] = 0;
      en[c] = 1'b1;
      ex[c] = 5'h0;
    end
  endtask

  // Factory setpoints on circuit 0 across the band edges.
  task automatic dflt_run();
    foreach (tl[i])
      mc(0, tl[i], 5, 100, 1'b0);
  endtask

  task automatic prog(int c);
    wr(8'h00, {16'h0, MOD, 8'(c)});
    wr(8'h08, {16'h0, 16'(m[c])});
    wr(8'h0c, 32'(db[c]));
    wr(8'h10, {16'h0, 16'(lt[c])});
    wr(8'h14, {16'h0, 16'(ht[c])});
    wr(8'h18, 32'(lc[c]));
    wr(8'h1c, 32'(hc[c]));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hde3ae87a));
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    meas = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    defaults();
    foreach (ra[i])
      rd(ra[i], rv[i]);
    dflt_run();
    for (int c = 0; c < 4; c++)
    begin
      m[c] = int'($urandom_range(300)) - 20;
      db[c] = $urandom_range(10);
      lt[c] = m[c] - 1 - int'($urandom_range(20));
      ht[c] = m[c] + 1 + int'($urandom_range(20));
      lc[c] = 1 + $urandom_range(29);
      hc[c] = lc[c] + 1 + $urandom_range(28);
      prog(c);
      repeat (30)
      begin
        t = m[c] + int'($urandom_range(48)) - 24;
        du = $urandom_range(1) ? 100 : 1 + $urandom_range(99);
        cu = (($urandom_range(1) ? lc[c] : hc[c]) * 5 * du) / 100;
        mc(c, t, cu + $urandom_range(2), du, 1'($urandom_range(1)));
      end
      rd(8'h20, 32'(ex[c]));
    end
    wr(8'h00, {16'h0, MOD, 8'h01});
    m[1] = 32766;
    wr(8'h08, 32'h7ffe);
    mc(1, 400, 0, 100, 1'b0);
    mc(1, -60, 0, 100, 1'b0);
    mc(1, -60, 300, 0, 1'b1);
    m[1] = 32767;
    wr(8'h08, 32'h7fff);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h7fff);
    mc(1, -60, 0, 100, 1'b0);
    en[1] = 1'b0;
    wr(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h08, 32'h64);
    mc(1, -60, 0, 100, 1'b0);
    en[1] = 1'b1;
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h7fff);
    i_kp.store(8'h1c, 32'h3c);
    rd(8'h1c, 32'(hc[1]));
    i_kp.set_switch(1'b1);
    repeat (4) @(posedge clk);
    i_kp.store(8'h1c, 32'h3c);
    rd(8'h1c, 32'h3c);
    rd(8'h20, 32'h20);
    rd(8'h24, 32'h0000_ffc4);
    wr(8'h00, {16'h0, 8'h02, 8'h00});
    rd(8'h00, {16'h0, MOD, 8'h01});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    defaults();
    dflt_run();
    wrap_up();
  end
endmodule
